// File: rtl/bcs_charger.sv
// Charge-control state machine with safety timers, temperature gating and register port.
// Assumes analog comparator results are synchronous to CORE_CLK and already filtered.
//
// What this block does
// - Each cycle starts in precondition at one tenth current until above threshold.
// - Precondition timer expiry before threshold enters the time-out fault state.
// - Fast-charge runs constant current until termination voltage, then top-off.
// - Total timeout in fast-charge goes to end-of-charge, restarting after 32 ms.
// - Top-off regulates 4.20 V; end-of-charge current moves to end-of-charge.
// - Total timeout in top-off goes to end-of-charge, restarting at 205 mV drop.
// - End-of-charge is high impedance; restarts when cell falls 205 mV below termination.
// - Absent battery, input undervoltage or overvoltage forces suspend; clearing restarts.
// - Software suspend bit holds suspend; clearing it starts a new cycle.
// - State-machine interrupt on entering or leaving end-of-charge when enabled.
// - Live charger flag is 1 only in end-of-charge.
// - Three status flags set on group interrupt, cleared by the read returning them.
// - Two-bit state code: 11 precondition, 10 fast/top-off, 01 end, 00 else.
// - Precondition timer select: 40, 60, 80 minutes, or disabled.
// - Total timer select: 3, 4, 5 hours, or disabled.
// - Timers run at half speed, doubling their period, while charge current is reduced.
// - Timer interrupt on precondition or total expiry when enabled.
// - Live timer flag is 1 when either timeout has occurred.
// - Open-drain indicator sinks while charging, released in all other states.
// - Thermistor outside hot or cold threshold suspends charging as temperature fault.
// - Temperature interrupt on leaving or returning to range when enabled.
// - Live temperature flag is 1 while temperature is in range.
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module bcs_charger import bcs_pkg::*; #(
	parameter int RELAX_CYCLES = RELAX_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic [1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire bcs_analog_t ANALOG,
	output bcs_drive_t DRIVE,
	output logic CHARGING_INDICATOR_N_O,
	output logic CHARGING_INDICATOR_N_OE
);
	bcs_state_t state_r;
	bcs_state_t state_nxt;
	logic [31:0] ctrl_r;
	logic [31:0] irq_en_r;
	logic [31:0] readdata_r;
	logic ack_r;
	logic [21:0] relax_r;
	logic relax_pending_r;
	logic temp_ok_r;
	logic in_eoc_r;
	logic pre_exp;
	logic tot_exp;
	logic pre_exp_r;
	logic tot_exp_r;
	logic tim_live_r;
	logic [8:0] pre_limit;
	logic [8:0] tot_limit;
	logic supply_bad;
	logic sw_suspend;
	logic wr_ok;
	logic rd_take;
	logic rd_status;
	logic [1:0] code;
	logic charging;
	logic set_chg;
	logic set_tim;
	logic set_tmp;
	logic chg_irq;
	logic tim_irq;
	logic tmp_irq;
	logic [1:0] pre_sel;
	logic [1:0] tot_sel;

	assign pre_sel = ctrl_r[CTRL_PRE_SEL +: 2];
	assign tot_sel = ctrl_r[CTRL_TOT_SEL +: 2];
	assign sw_suspend = ctrl_r[CTRL_SUSPEND];
	assign supply_bad = !ANALOG.bat_present || ANALOG.in_uvlo || ANALOG.in_ovp;

	// One wait cycle per access keeps read data registered and the clear tied to acceptance.
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_r;
	assign wr_ok = AVS_WRITE && ack_r;
	// Flags clear at the edge that copies them into read data, so an event in the wait cycle
	// stays pending for the next read instead of being wiped unseen.
	assign rd_take = AVS_READ && !ack_r;
	assign rd_status = rd_take && (AVS_ADDRESS == REG_STATUS);

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (AVS_READ || AVS_WRITE) && !ack_r;
		end
	end

	always_comb begin
		case (pre_sel)
			2'h0: pre_limit = 9'(PRE_MIN0);
			2'h1: pre_limit = 9'(PRE_MIN1);
			2'h2: pre_limit = 9'(PRE_MIN2);
			default: pre_limit = 9'h000;
		endcase
		case (tot_sel)
			2'h0: tot_limit = 9'(TOT_MIN0);
			2'h1: tot_limit = 9'(TOT_MIN1);
			2'h2: tot_limit = 9'(TOT_MIN2);
			default: tot_limit = 9'h000;
		endcase
	end

	bcs_timer u_pre_timer (
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.clr(state_r != BCS_PRECOND),
		.run(state_r == BCS_PRECOND && pre_sel != TMO_DISABLED),
		.stretch(ANALOG.current_reduced),
		.limit_min(pre_limit),
		.expired(pre_exp)
	);

	bcs_timer u_tot_timer (
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.clr(state_r != BCS_FAST && state_r != BCS_TOPOFF && state_r != BCS_PRECOND),
		.run((state_r == BCS_FAST || state_r == BCS_TOPOFF || state_r == BCS_PRECOND)
			&& tot_sel != TMO_DISABLED),
		.stretch(ANALOG.current_reduced),
		.limit_min(tot_limit),
		.expired(tot_exp)
	);

	always_comb begin
		state_nxt = state_r;
		if (supply_bad || sw_suspend) begin
			state_nxt = BCS_SUSPEND;
		end else if (!ANALOG.temp_ok) begin
			state_nxt = BCS_TEMP_FAULT;
		end else begin
			case (state_r)
				BCS_SUSPEND, BCS_TEMP_FAULT: state_nxt = BCS_PRECOND;
				BCS_PRECOND: begin
					if (ANALOG.above_precond) begin
						state_nxt = BCS_FAST;
					end else if (pre_exp) begin
						state_nxt = BCS_TIMEOUT;
					end
				end
				BCS_FAST: begin
					if (ANALOG.at_term) begin
						state_nxt = BCS_TOPOFF;
					end else if (tot_exp) begin
						state_nxt = BCS_EOC;
					end
				end
				BCS_TOPOFF: begin
					if (ANALOG.eoc_current || tot_exp) begin
						state_nxt = BCS_EOC;
					end
				end
				BCS_EOC: begin
					if ((relax_pending_r && relax_r == 22'h00_0000) || ANALOG.below_recharge) begin
						state_nxt = BCS_PRECOND;
					end
				end
				default: state_nxt = state_r;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_r <= BCS_SUSPEND;
		end else begin
			state_r <= state_nxt;
		end
	end

	// The relax delay applies only when fast-charge timed out without reaching termination.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			relax_r <= 22'h00_0000;
			relax_pending_r <= 1'b0;
		end else if (state_r == BCS_FAST && state_nxt == BCS_EOC) begin
			relax_r <= 22'(RELAX_CYCLES - 1);
			relax_pending_r <= 1'b1;
		end else if (state_r != BCS_EOC) begin
			relax_pending_r <= 1'b0;
		end else if (relax_r != 22'h00_0000) begin
			relax_r <= relax_r - 22'h00_0001;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_r <= CTRL_RESET;
			irq_en_r <= IRQ_EN_RESET;
		end else if (wr_ok) begin
			if (AVS_ADDRESS == REG_CTRL) begin
				for (int b = 0; b < 4; b++) begin
					if (AVS_BYTEENABLE[b]) begin
						ctrl_r[b*8 +: 8] <= AVS_WRITEDATA[b*8 +: 8] & 8'((32'h0000_001F) >> (b*8));
					end
				end
			end else if (AVS_ADDRESS == REG_IRQ_EN) begin
				for (int b = 0; b < 4; b++) begin
					if (AVS_BYTEENABLE[b]) begin
						irq_en_r[b*8 +: 8] <= AVS_WRITEDATA[b*8 +: 8] & 8'((32'h0000_01FF) >> (b*8));
					end
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			temp_ok_r <= 1'b1;
			in_eoc_r <= 1'b0;
			pre_exp_r <= 1'b0;
			tot_exp_r <= 1'b0;
		end else begin
			temp_ok_r <= ANALOG.temp_ok;
			in_eoc_r <= (state_r == BCS_EOC);
			pre_exp_r <= pre_exp;
			tot_exp_r <= tot_exp;
		end
	end

	// The flag stays up through the fault state and drops when a fresh cycle begins.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tim_live_r <= 1'b0;
		end else if (pre_exp || tot_exp) begin
			tim_live_r <= 1'b1;
		end else if (state_r == BCS_PRECOND) begin
			tim_live_r <= 1'b0;
		end
	end

	assign set_chg = irq_en_r[EN_CHG_GRP] &&
		((irq_en_r[EN_EOC_IN] && state_r == BCS_EOC && !in_eoc_r) ||
		(irq_en_r[EN_EOC_OUT] && state_r != BCS_EOC && in_eoc_r));
	assign set_tim = irq_en_r[EN_TIM_GRP] &&
		((irq_en_r[EN_TIM_PRE] && pre_exp && !pre_exp_r) ||
		(irq_en_r[EN_TIM_TOT] && tot_exp && !tot_exp_r));
	assign set_tmp = irq_en_r[EN_TMP_GRP] &&
		((irq_en_r[EN_TMP_OUT] && !ANALOG.temp_ok && temp_ok_r) ||
		(irq_en_r[EN_TMP_IN] && ANALOG.temp_ok && !temp_ok_r));

	bcs_irq_flag u_chg_flag (
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.set(set_chg),
		.rd_clr(rd_status),
		.flag(chg_irq)
	);

	bcs_irq_flag u_tim_flag (
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.set(set_tim),
		.rd_clr(rd_status),
		.flag(tim_irq)
	);

	bcs_irq_flag u_tmp_flag (
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.set(set_tmp),
		.rd_clr(rd_status),
		.flag(tmp_irq)
	);

	always_comb begin
		case (state_r)
			BCS_PRECOND: code = 2'h3;
			BCS_FAST, BCS_TOPOFF: code = 2'h2;
			BCS_EOC: code = 2'h1;
			default: code = 2'h0;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			readdata_r <= 32'h0000_0000;
		end else if (rd_take) begin
			readdata_r <= 32'h0000_0000;
			if (AVS_ADDRESS == REG_CTRL) begin
				readdata_r <= ctrl_r;
			end else if (AVS_ADDRESS == REG_IRQ_EN) begin
				readdata_r <= irq_en_r;
			end else if (AVS_ADDRESS == REG_STATUS) begin
				readdata_r[ST_CODE +: 2] <= code;
				readdata_r[ST_CHG_LIVE] <= (state_r == BCS_EOC);
				readdata_r[ST_TIM_LIVE] <= tim_live_r;
				readdata_r[ST_TMP_LIVE] <= ANALOG.temp_ok;
				readdata_r[ST_CHG_IRQ] <= chg_irq;
				readdata_r[ST_TIM_IRQ] <= tim_irq;
				readdata_r[ST_TMP_IRQ] <= tmp_irq;
				readdata_r[ST_PRECHG] <= DRIVE.precharge;
				readdata_r[ST_CC] <= DRIVE.cc_mode;
				readdata_r[ST_CV] <= DRIVE.cv_mode;
				readdata_r[ST_HIZ] <= DRIVE.hi_z;
			end
		end
	end
	assign AVS_READDATA = readdata_r;

	assign charging = (state_nxt == BCS_PRECOND) || (state_nxt == BCS_FAST) || (state_nxt == BCS_TOPOFF);

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			DRIVE <= '{precharge: 1'b0, cc_mode: 1'b0, cv_mode: 1'b0, hi_z: 1'b1};
		end else begin
			DRIVE.precharge <= (state_nxt == BCS_PRECOND);
			DRIVE.cc_mode <= (state_nxt == BCS_FAST);
			DRIVE.cv_mode <= (state_nxt == BCS_TOPOFF);
			DRIVE.hi_z <= !(state_nxt == BCS_PRECOND || state_nxt == BCS_FAST
				|| state_nxt == BCS_TOPOFF);
		end
	end

	// The pin follows the next state, so the lamp and the drive mode switch on the same edge.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CHARGING_INDICATOR_N_OE <= 1'b0;
		end else begin
			CHARGING_INDICATOR_N_OE <= charging;
		end
	end
	assign CHARGING_INDICATOR_N_O = 1'b0;
endmodule

// File: rtl/bcs_pkg.sv
// Package for the battery charge state machine: register map, field layout, timing counts.
// Assumes a 50 MHz core clock and a word-addressed Avalon-MM register port.
package bcs_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int RELAX_MS = 32;
	localparam int RELAX_CYC = RELAX_MS * (CLK_HZ / 1000);
	localparam int MS_CYC = CLK_HZ / 1000;
	// Timeouts in minutes.
	localparam int PRE_MIN0 = 40;
	localparam int PRE_MIN1 = 60;
	localparam int PRE_MIN2 = 80;
	localparam int TOT_MIN0 = 3 * 60;
	localparam int TOT_MIN1 = 4 * 60;
	localparam int TOT_MIN2 = 5 * 60;
	localparam logic [1:0] TMO_DISABLED = 2'h3;
	// Word addresses (byte address = 4 * index).
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_IRQ_EN = 2'h1;
	localparam logic [1:0] REG_STATUS = 2'h2;
	// Control register fields.
	localparam int CTRL_SUSPEND = 0;
	localparam int CTRL_PRE_SEL = 1;
	localparam int CTRL_TOT_SEL = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// Interrupt enable register fields.
	localparam int EN_CHG_GRP = 0;
	localparam int EN_EOC_IN = 1;
	localparam int EN_EOC_OUT = 2;
	localparam int EN_TIM_GRP = 3;
	localparam int EN_TIM_PRE = 4;
	localparam int EN_TIM_TOT = 5;
	localparam int EN_TMP_GRP = 6;
	localparam int EN_TMP_OUT = 7;
	localparam int EN_TMP_IN = 8;
	localparam logic [31:0] IRQ_EN_RESET = 32'h0000_0000;
	// Status register fields.
	localparam int ST_CODE = 0;
	localparam int ST_CHG_LIVE = 2;
	localparam int ST_TIM_LIVE = 3;
	localparam int ST_TMP_LIVE = 4;
	localparam int ST_CHG_IRQ = 5;
	localparam int ST_TIM_IRQ = 6;
	localparam int ST_TMP_IRQ = 7;
	localparam int ST_PRECHG = 8;
	localparam int ST_CC = 9;
	localparam int ST_CV = 10;
	localparam int ST_HIZ = 11;

	typedef enum {
		BCS_SUSPEND, BCS_PRECOND, BCS_FAST, BCS_TOPOFF, BCS_EOC, BCS_TIMEOUT, BCS_TEMP_FAULT
	} bcs_state_t;

	typedef struct packed {
		logic bat_present;
		logic in_uvlo;
		logic in_ovp;
		logic above_precond;
		logic at_term;
		logic below_recharge;
		logic eoc_current;
		logic temp_ok;
		logic current_reduced;
	} bcs_analog_t;

	typedef struct packed {
		logic precharge;
		logic cc_mode;
		logic cv_mode;
		logic hi_z;
	} bcs_drive_t;
endpackage

// File: rtl/bcs_timer.sv
// Minute-based safety timer with a millisecond prescaler and a stretch input.
// Assumes clear and run come from the charge state machine in the same clock domain.
`timescale 1ns/1ps
module bcs_timer import bcs_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic run,
	input wire logic stretch,
	input wire logic [8:0] limit_min,
	output logic expired
);
	logic [15:0] ms_r;
	logic [15:0] sec_ms_r;
	logic [5:0] sec_r;
	logic [8:0] min_r;
	logic half_r;
	logic tick;
	logic min_tick;

	// Under reduced current every other millisecond is dropped, doubling the period.
	assign tick = run && !expired && (!stretch || half_r);
	assign min_tick = (sec_ms_r == 16'(999)) && (sec_r == 6'(59));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_r <= 16'h0000;
			half_r <= 1'b0;
		end else if (clr) begin
			ms_r <= 16'h0000;
			half_r <= 1'b0;
		end else if (run && !expired) begin
			if (ms_r == 16'(MS_CYC - 1)) begin
				ms_r <= 16'h0000;
				half_r <= !half_r;
			end else begin
				ms_r <= ms_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_ms_r <= 16'h0000;
			sec_r <= 6'h00;
			min_r <= 9'h000;
		end else if (clr) begin
			sec_ms_r <= 16'h0000;
			sec_r <= 6'h00;
			min_r <= 9'h000;
		end else if (tick && ms_r == 16'(MS_CYC - 1)) begin
			sec_ms_r <= (sec_ms_r == 16'(999)) ? 16'h0000 : sec_ms_r + 16'h0001;
			if (sec_ms_r == 16'(999)) begin
				sec_r <= (sec_r == 6'(59)) ? 6'h00 : sec_r + 6'h01;
			end
			if (min_tick) begin
				min_r <= min_r + 9'h001;
			end
		end
	end

	assign expired = (min_r >= limit_min) && (limit_min != 9'h000);
endmodule

// File: rtl/bcs_irq_flag.sv
// Sticky interrupt status flag, cleared by the read that returns it.
// Assumes the read strobe lasts one cycle per accepted read.
`timescale 1ns/1ps
module bcs_irq_flag (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic set,
	input wire logic rd_clr,
	output logic flag
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else if (set) begin
			flag <= 1'b1;
		end else if (rd_clr) begin
			flag <= 1'b0;
		end
	end
endmodule

// File: sim/bcs_cell_model.sv
// Behavioural cell and input supply presenting comparator levels to the charger.
// Assumes the bench commands each condition; levels change just after a clock edge.
`timescale 1ns/1ps
module bcs_cell_model import bcs_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire bcs_analog_t cmd,
	input wire logic [3:0] lag,
	output bcs_analog_t analog
);
	logic [3:0] cnt_r;
	// Supply limits, cell presence, recharge level and thermistor range all follow cmd.
	// A slow cell holds its old levels for lag cycles, so the charger never sees an instant change.
	// Reset shows a healthy cell, so the charger sees no false temperature edge on release.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			analog <= '{bat_present: 1'b1, temp_ok: 1'b1, default: 1'b0};
			cnt_r <= 4'h0;
		end else if (analog == cmd) begin
			cnt_r <= 4'h0;
		end else if (cnt_r >= lag) begin
			analog <= cmd;
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule

// File: sim/bcs_charger_monitor.sv
// Checker for the charge state machine, watching the top module ports only.
// Assumes it is bound to the top module and analog levels are synchronous to CORE_CLK.
`timescale 1ns/1ps
module bcs_charger_monitor import bcs_pkg::*; #(
	parameter int RELAX_CYCLES = RELAX_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic [1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire bcs_analog_t ANALOG,
	input wire bcs_drive_t DRIVE,
	input wire logic CHARGING_INDICATOR_N_O,
	input wire logic CHARGING_INDICATOR_N_OE
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	logic st_ack;
	logic [31:0] rd;
	assign st_ack = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == REG_STATUS;
	assign rd = AVS_READDATA;
	AST_OD_LOW: assert property (CHARGING_INDICATOR_N_O == 1'b0)
		else $error("indicator pin driven high");
	// The indicator and the drive mode are loaded on the same edge, so they must always agree.
	AST_IND_SINK: assert property (!DRIVE.hi_z |-> CHARGING_INDICATOR_N_OE)
		else $error("indicator idle while charging");
	AST_IND_OFF: assert property (DRIVE.hi_z |-> !CHARGING_INDICATOR_N_OE)
		else $error("indicator sinking while not charging");
	AST_ONEHOT: assert property ($onehot0({DRIVE.precharge, DRIVE.cc_mode, DRIVE.cv_mode}) &&
		DRIVE.hi_z == !(DRIVE.precharge | DRIVE.cc_mode | DRIVE.cv_mode))
		else $error("drive mode not one-hot");
	AST_START_PRE: assert property ($fell(DRIVE.hi_z) |-> DRIVE.precharge)
		else $error("charge cycle not started in precondition");
	AST_SUSPEND: assert property (!ANALOG.bat_present || ANALOG.in_uvlo || ANALOG.in_ovp
		|-> ##[1:2] DRIVE.hi_z)
		else $error("charging with supply or cell fault");
	AST_TEMP: assert property (!ANALOG.temp_ok |-> ##[1:2] DRIVE.hi_z)
		else $error("charging out of temperature range");
	AST_CODE: assert property (st_ack |-> (rd[1:0] == 2'h3) == rd[8] &&
		(rd[1:0] == 2'h2) == (rd[9] | rd[10]) && rd[1] == !rd[11])
		else $error("state code disagrees with drive mode");
	AST_LIVE_EOC: assert property (st_ack |-> rd[2] == (rd[1:0] == 2'h1))
		else $error("live charger flag wrong");
endmodule

// File: sim/tb_bcs_charger.sv
// Self-checking bench for the charge state machine through its register port.
// Assumes the package register map and a cell model on the analog side.
`timescale 1ns/1ps
module tb_bcs_charger import bcs_pkg::*;;
	logic CORE_CLK, RESET_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, ind_o, ind_oe;
	logic [1:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
	logic [3:0] AVS_BYTEENABLE, lag;
	bcs_analog_t ANALOG, cmd;
	bcs_drive_t DRIVE;
	int n_mismatch, compares;
	bcs_analog_t row_a [11];
	logic [31:0] row_e [11];
	bcs_charger #(.RELAX_CYCLES(8)) bcs_charger_i (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .ANALOG(ANALOG), .DRIVE(DRIVE),
		.CHARGING_INDICATOR_N_O(ind_o), .CHARGING_INDICATOR_N_OE(ind_oe));
	bcs_cell_model bcs_cell_model_i (.clk(CORE_CLK), .rst_n(RESET_N), .cmd(cmd), .lag(lag), .analog(ANALOG));
	initial begin
		CORE_CLK = 1'b0;
		forever #10 CORE_CLK = ~CORE_CLK;
	end
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// The request stands until the rising edge at which waitrequest is sampled low; data is taken there.
	task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge CORE_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			report_and_stop();
		end
		r = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask
	task automatic rd_chk(input logic [1:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q & m, e);
	endtask
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		bus(1'b1, a, d, q);
	endtask
	task automatic go(input bcs_analog_t a);
		@(posedge CORE_CLK);
		cmd <= a;
		repeat (12) @(posedge CORE_CLK);
	endtask
	initial begin
		RESET_N = 1'b0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_ADDRESS = 2'h0;
		AVS_WRITEDATA = 32'h0000_0000;
		AVS_BYTEENABLE = 4'hF;
		lag = 4'h0;
		cmd = 9'h102;
		n_mismatch = 0;
		compares = 0;
		row_a = '{9'h102, 9'h122, 9'h132, 9'h136, 9'h10A, 9'h002, 9'h182, 9'h142, 9'h102, 9'h100, 9'h103};
		row_e = '{32'h113, 32'h212, 32'h412, 32'h815, 32'h113, 32'h810, 32'h810, 32'h810, 32'h113,
			32'h800, 32'h113};
		repeat (20) @(posedge CORE_CLK);
		RESET_N <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			go(row_a[i]);
			rd_chk(REG_STATUS, 32'hFFFF_FF1F, row_e[i]);
			$display("row %0d done", i);
		end
		AVS_BYTEENABLE <= 4'h0;
		wr(REG_CTRL, 32'h0000_001F);
		AVS_BYTEENABLE <= 4'hF;
		rd_chk(REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(REG_CTRL, 32'hFFFF_FFFF);
		rd_chk(REG_CTRL, 32'hFFFF_FFFF, 32'h0000_001F);
		rd_chk(REG_STATUS, 32'h0000_0F03, 32'h0000_0800);
		wr(REG_CTRL, 32'h0000_0000);
		repeat (4) @(posedge CORE_CLK);
		rd_chk(REG_STATUS, 32'h0000_0F03, 32'h0000_0103);
		wr(2'h3, 32'hFFFF_FFFF);
		rd_chk(2'h3, 32'hFFFF_FFFF, 32'h0000_0000);
		$display("registers done");
		lag <= 4'h5;
		wr(REG_IRQ_EN, 32'h0000_01FF);
		bus(1'b0, REG_STATUS, 32'h0000_0000, q);
		go(9'h100);
		rd_chk(REG_STATUS, 32'h0000_00F0, 32'h0000_0080);
		rd_chk(REG_STATUS, 32'h0000_00E0, 32'h0000_0000);
		go(9'h102);
		rd_chk(REG_STATUS, 32'h0000_00F0, 32'h0000_0090);
		wr(REG_IRQ_EN, 32'h0000_01BF);
		go(9'h100);
		rd_chk(REG_STATUS, 32'h0000_00E0, 32'h0000_0000);
		wr(REG_IRQ_EN, 32'h0000_01FF);
		go(9'h102);
		bus(1'b0, REG_STATUS, 32'h0000_0000, q);
		go(9'h122);
		go(9'h136);
		rd_chk(REG_STATUS, 32'h0000_00E7, 32'h0000_0025);
		go(9'h10A);
		rd_chk(REG_STATUS, 32'h0000_00E4, 32'h0000_0020);
		wr(REG_IRQ_EN, 32'h0000_01FB);
		go(9'h136);
		bus(1'b0, REG_STATUS, 32'h0000_0000, q);
		go(9'h10A);
		rd_chk(REG_STATUS, 32'h0000_0020, 32'h0000_0000);
		$display("interrupts done");
		wr(REG_CTRL, 32'h0000_0015);
		RESET_N <= 1'b0;
		repeat (20) @(posedge CORE_CLK);
		RESET_N <= 1'b1;
		rd_chk(REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_chk(REG_IRQ_EN, 32'hFFFF_FFFF, 32'h0000_0000);
		$display("reset done");
		report_and_stop();
	end
endmodule
bind bcs_charger bcs_charger_monitor #(.RELAX_CYCLES(RELAX_CYCLES)) bcs_charger_monitor_i (
	.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .ANALOG(ANALOG), .DRIVE(DRIVE),
	.CHARGING_INDICATOR_N_O(CHARGING_INDICATOR_N_O), .CHARGING_INDICATOR_N_OE(CHARGING_INDICATOR_N_OE));
